// ---- core/ifs_input_shutoff.sv ----
// Input terminal function mapping, speed priority and output shutoff control
// Summary of operation
// R1: Same function on several terminals is ORed
// R2: Speed priority inching, multi-speed, then PID
// R3: Shutoff input stands in for missing functions
// R4: Multi-speed and remote setting share signals
// R5: V/F switch selects second set; holds running
// R6: Current select disables voltage input
// R7: Fast shutoff/run-enable response, others slower
// R8: Shutoff logic settings 0, 2, 4
// R9: Terminal and communication shutoff combination table
// R10: Shutoff while running cuts output at once
// R11: Shutoff blocks running despite start
// R12: Start removal decelerates, shutoff coasts
// R13: Shutoff defaults to its terminal, code 24
// R14: Shutoff acts in every operation mode
// R15: Code 3 selects the second set
// R16: Logic setting writable only when group zero
// R17: Seven selections, 9999 means no function
// R18: Function codes 3,4,5,10,12,14,18
// R19: Inputs sampled on clock, level logic
//
// Our own choices: the address map and the plain strobed port.
module ifs_input_shutoff #(
  parameter int unsigned FAST_CNT = ifs_pkg::FAST_HOLD,
  parameter int unsigned SLOW_CNT = ifs_pkg::SLOW_HOLD
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ifs_pkg::NUM_TERM-1:0] term_in,
  input wire logic start_cmd,
  input wire logic motor_running,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic gate_enable,
  output logic coast_stop,
  output logic decel_stop,
  output logic panel_op_allowed,
  output logic second_set_active,
  output logic vf_control_active,
  output logic voltage_input_enable,
  output logic [1:0] speed_source,
  output logic [3:0] speed_step,
  output logic remote_accel,
  output logic remote_decel,
  output logic remote_clear
);
  localparam int unsigned NT = ifs_pkg::NUM_TERM;
  localparam int unsigned FW = $bits(ifs_pkg::ifs_func_s);

  // Matches one terminal code against a wanted function
  function automatic logic code_is(input ifs_pkg::ifs_code_t code, input ifs_pkg::ifs_code_t want);
    code_is = (code == want) && (code != ifs_pkg::FN_NONE);
  endfunction

  // Configuration registers
  logic [2:0] logic_sel_q; // Shutoff logic setting
  logic [7:0] group_q; // User group read selection
  logic [3:0] mode_q; // Operation mode selection
  ifs_pkg::ifs_code_t term_fn_q [NT]; // Per-terminal function selection
  logic comm_shutoff_q; // Shutoff request from communication
  logic remote_mode_q; // Speed signals act as remote setting
  logic [NT-1:0] term_q; // Sampled terminals
  logic [31:0] rdata_q; // Read data
  // Decoded and filtered functions
  ifs_pkg::ifs_func_s func_raw;
  ifs_pkg::ifs_func_s func_f;
  logic run_en_raw;
  logic shut_term_raw;
  logic run_en_assigned;
  logic panel_assigned;
  logic shutoff_req;
  logic [1:0] fast_f;
  logic run_en_f;
  logic shutoff_active;
  // Effective run permission and output registers
  logic run_allow;
  logic gate_q;
  logic coast_q;
  logic decel_q;
  logic panel_q;
  logic second_q;
  logic vf_q;
  logic volt_en_q;
  ifs_pkg::ifs_speed_src_e src_q;
  ifs_pkg::ifs_speed_src_e src_d;
  logic [3:0] step_q;
  logic [2:0] remote_q;

  // Terminals are taken as synchronous levels
  // R19: clocked sampling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      term_q <= '0;
    end else begin
      term_q <= term_in;
    end
  end

  // Configuration writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      logic_sel_q <= ifs_pkg::LOGIC_RESET;
      group_q <= ifs_pkg::GROUP_OPEN;
      mode_q <= '0;
      comm_shutoff_q <= 1'b0;
      remote_mode_q <= 1'b0;
      // R13: shutoff on its own terminal
      for (int i = 0; i < NT; i++) begin
        term_fn_q[i] <= ifs_pkg::TERM_RESET[i];
      end
    end else if (reg_we) begin
      // R16: group gate on logic setting
      // R8: only 0, 2 and 4 are kept
      if (reg_addr == ifs_pkg::ADDR_LOGIC && group_q == ifs_pkg::GROUP_OPEN &&
          (reg_wdata[2:0] == ifs_pkg::LOGIC_NO || reg_wdata[2:0] == ifs_pkg::LOGIC_NC ||
           reg_wdata[2:0] == ifs_pkg::LOGIC_SPLIT) && reg_wdata[31:3] == '0) begin
        logic_sel_q <= reg_wdata[2:0];
      end
      if (reg_addr == ifs_pkg::ADDR_GROUP) begin
        group_q <= reg_wdata[7:0];
      end
      if (reg_addr == ifs_pkg::ADDR_MODE) begin
        mode_q <= reg_wdata[3:0];
      end
      if (reg_addr == ifs_pkg::ADDR_CTRL) begin
        comm_shutoff_q <= reg_wdata[0];
        remote_mode_q <= reg_wdata[1];
      end
      // R17: seven function selections
      for (int i = 0; i < NT; i++) begin
        if (reg_addr == ifs_pkg::ADDR_TERM0 + 8'(4 * i)) begin
          term_fn_q[i] <= reg_wdata[ifs_pkg::CODE_W-1:0];
        end
      end
    end
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_re) begin
      rdata_q <= '0;
      case (reg_addr)
        ifs_pkg::ADDR_LOGIC: rdata_q <= {29'h0, logic_sel_q};
        ifs_pkg::ADDR_GROUP: rdata_q <= {24'h0, group_q};
        ifs_pkg::ADDR_MODE: rdata_q <= {28'h0, mode_q};
        ifs_pkg::ADDR_CTRL: rdata_q <= {30'h0, remote_mode_q, comm_shutoff_q};
        ifs_pkg::ADDR_STATUS: rdata_q <= {12'h0, run_allow, gate_q, run_en_f, shutoff_active, 6'h0, func_f};
        default: begin
          for (int i = 0; i < NT; i++) begin
            if (reg_addr == ifs_pkg::ADDR_TERM0 + 8'(4 * i)) begin
              rdata_q <= {18'h0, term_fn_q[i]};
            end
          end
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // Terminal to function decoding
  // A terminal set to no function never matches, so it drives nothing
  always_comb begin
    func_raw = '0;
    run_en_raw = 1'b0;
    shut_term_raw = 1'b0;
    run_en_assigned = 1'b0;
    panel_assigned = 1'b0;
    // R1: OR over all terminals with the code
    // R18: function codes
    for (int i = 0; i < NT; i++) begin
      func_raw.low |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_LOW);
      func_raw.mid |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_MID);
      func_raw.high |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_HIGH);
      func_raw.second |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_SECOND);
      func_raw.cur_sel |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_CUR_SEL);
      func_raw.inch |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_INCH);
      func_raw.fifteen |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_FIFTEEN);
      func_raw.panel_il |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_PANEL_IL);
      func_raw.pid |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_PID);
      func_raw.vf |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_VF);
      run_en_raw |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_RUN_EN);
      shut_term_raw |= term_q[i] & code_is(term_fn_q[i], ifs_pkg::FN_SHUTOFF);
      run_en_assigned |= code_is(term_fn_q[i], ifs_pkg::FN_RUN_EN);
      panel_assigned |= code_is(term_fn_q[i], ifs_pkg::FN_PANEL_IL);
    end
  end

  // Terminal and communication sources combined per logic setting
  always_comb begin
    // R9: enable table, anything else shuts off
    case (logic_sel_q)
      ifs_pkg::LOGIC_NO: shutoff_req = shut_term_raw | comm_shutoff_q;
      ifs_pkg::LOGIC_NC: shutoff_req = ~(shut_term_raw & comm_shutoff_q);
      ifs_pkg::LOGIC_SPLIT: shutoff_req = ~(shut_term_raw & ~comm_shutoff_q);
      default: shutoff_req = 1'b1;
    endcase
  end

  // R7: fast path for run enable and shutoff
  ifs_filter #(.WIDTH(2), .HOLD(FAST_CNT)) u_fast (
    .clk(clk),
    .rst(rst),
    .d({run_en_raw, shutoff_req}),
    .q(fast_f)
  );

  // R7: slow path for the other functions
  ifs_filter #(.WIDTH(FW), .HOLD(SLOW_CNT)) u_slow (
    .clk(clk),
    .rst(rst),
    .d(func_raw),
    .q(func_f)
  );

  assign run_en_f = fast_f[1];
  assign shutoff_active = fast_f[0];

  // R3: shutoff stands in for an unassigned run enable
  // R14: no operation mode term in the shutoff path
  assign run_allow = ~shutoff_active & (run_en_assigned ? run_en_f : 1'b1);

  // Output stage control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
      coast_q <= 1'b0;
      decel_q <= 1'b0;
    end else begin
      // R10: cut at once
      // R11: start is refused while shut off
      gate_q <= run_allow & start_cmd;
      // R12: shutoff coasts, start removal decelerates
      coast_q <= ~run_allow;
      decel_q <= run_allow & ~start_cmd & motor_running;
    end
  end

  // Panel operation permission in the interlock mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      panel_q <= 1'b1;
    end else if (mode_q != ifs_pkg::MODE_INTERLOCK) begin
      panel_q <= 1'b1;
    end else begin
      // R3: shutoff shares the interlock when unassigned
      panel_q <= panel_assigned ? func_f.panel_il : ~shutoff_active;
    end
  end

  // Second set and control method
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_q <= 1'b0;
      vf_q <= 1'b0;
    end else begin
      // R15: second set select
      // R5: V/F switch also picks the second set
      second_q <= func_f.second | func_f.vf;
      // R5: control method frozen while running
      if (!motor_running) begin
        vf_q <= func_f.vf;
      end
    end
  end

  // Speed source priority
  always_comb begin
    // R2: inching, multi-speed, PID, then analog
    if (func_f.inch) begin
      src_d = ifs_pkg::SRC_INCH;
    end else if (!remote_mode_q && (func_f.fifteen | func_f.high | func_f.mid | func_f.low)) begin
      src_d = ifs_pkg::SRC_MULTI;
    end else if (func_f.pid) begin
      src_d = ifs_pkg::SRC_PID;
    end else begin
      src_d = ifs_pkg::SRC_ANALOG;
    end
  end

  // Speed command outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_q <= ifs_pkg::SRC_ANALOG;
      step_q <= '0;
      remote_q <= '0;
      volt_en_q <= 1'b1;
    end else begin
      src_q <= src_d;
      // R4: one set of signals, one selection
      step_q <= remote_mode_q ? 4'h0 : {func_f.fifteen, func_f.high, func_f.mid, func_f.low};
      remote_q <= remote_mode_q ? {func_f.high, func_f.mid, func_f.low} : 3'h0;
      // R6: current select blocks voltage input
      volt_en_q <= ~func_f.cur_sel;
    end
  end

  assign reg_rdata = rdata_q;
  assign gate_enable = gate_q;
  assign coast_stop = coast_q;
  assign decel_stop = decel_q;
  assign panel_op_allowed = panel_q;
  assign second_set_active = second_q;
  assign vf_control_active = vf_q;
  assign voltage_input_enable = volt_en_q;
  assign speed_source = src_q;
  assign speed_step = step_q;
  assign remote_accel = remote_q[2];
  assign remote_decel = remote_q[1];
  assign remote_clear = remote_q[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  shutoff_cut_a: assert property (shutoff_active |=> !gate_q && coast_q) // R10
    else $error("Output not cut after shutoff");
  start_refused_a: assert property (start_cmd && !run_allow |=> !gate_q) // R11
    else $error("Gate enabled while shut off");
  coast_decel_a: assert property (!run_allow |=> !decel_q) // R12
    else $error("Controlled deceleration during shutoff");
  group_lock_a: assert property (reg_we && reg_addr == ifs_pkg::ADDR_LOGIC && group_q != ifs_pkg::GROUP_OPEN
                                 |=> $stable(logic_sel_q)) // R16
    else $error("Logic setting written while locked");
  logic_range_a: assert property (logic_sel_q == 3'h0 || logic_sel_q == 3'h2 || logic_sel_q == 3'h4) // R8
    else $error("Illegal logic setting held");
  volt_block_a: assert property (func_f.cur_sel |=> !volt_en_q) // R6
    else $error("Voltage input enabled with current select");
  second_set_a: assert property ((func_f.second || func_f.vf) |=> second_q) // R15
    else $error("Second set not selected");
  vf_hold_a: assert property (motor_running |=> $stable(vf_q)) // R5
    else $error("Control method changed while running");
  inch_first_a: assert property (func_f.inch |=> src_q == ifs_pkg::SRC_INCH) // R2
    else $error("Inching lost priority");
  split_table_a: assert property (logic_sel_q == 3'h4 && shut_term_raw && !comm_shutoff_q |-> !shutoff_req) // R9
    else $error("Split logic did not enable");
  // Without an interlock terminal the panel follows the filtered shutoff
  panel_share_a: assert property (mode_q == ifs_pkg::MODE_INTERLOCK && !panel_assigned // R3
                                  |=> panel_q == !$past(shutoff_active))
    else $error("Panel interlock not shared with shutoff");
endmodule // ifs_input_shutoff

// ---- core/ifs_pkg.sv ----
// Shared constants, register map and types for the input function and shutoff block
package ifs_pkg;
  // Number of programmable input terminals
  localparam int unsigned NUM_TERM = 7;
  // Width of a terminal function selection code
  localparam int unsigned CODE_W = 14;
  typedef logic [CODE_W-1:0] ifs_code_t;

  // Function selection codes
  localparam ifs_code_t FN_LOW = 14'h0000;
  localparam ifs_code_t FN_MID = 14'h0001;
  localparam ifs_code_t FN_HIGH = 14'h0002;
  localparam ifs_code_t FN_SECOND = 14'h0003;
  localparam ifs_code_t FN_CUR_SEL = 14'h0004;
  localparam ifs_code_t FN_INCH = 14'h0005;
  localparam ifs_code_t FN_FIFTEEN = 14'h0008;
  localparam ifs_code_t FN_RUN_EN = 14'h000A;
  localparam ifs_code_t FN_PANEL_IL = 14'h000C;
  localparam ifs_code_t FN_PID = 14'h000E;
  localparam ifs_code_t FN_VF = 14'h0012;
  localparam ifs_code_t FN_SHUTOFF = 14'h0018;
  localparam ifs_code_t FN_NONE = 14'h270F;

  // Reset values of the seven terminal selections, terminal 6 first
  localparam ifs_code_t [NUM_TERM-1:0] TERM_RESET = {14'h003E, FN_SHUTOFF, FN_HIGH, FN_MID, FN_LOW, 14'h003D,
                                                     14'h003C};

  // Register byte addresses
  localparam logic [7:0] ADDR_LOGIC = 8'h00;
  localparam logic [7:0] ADDR_GROUP = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_TERM0 = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;

  // Shutoff logic settings
  localparam logic [2:0] LOGIC_NO = 3'h0;
  localparam logic [2:0] LOGIC_NC = 3'h2;
  localparam logic [2:0] LOGIC_SPLIT = 3'h4;
  localparam logic [2:0] LOGIC_RESET = LOGIC_NO;
  // Operation mode that needs the panel interlock
  localparam logic [3:0] MODE_INTERLOCK = 4'h7;
  localparam logic [7:0] GROUP_OPEN = 8'h00;

  // Response bounds and derived filter hold counts at a 10 MHz clock
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned FAST_RESP_US = 2000;
  localparam int unsigned SLOW_RESP_US = 20000;
  // Half the bound, so sampling, filtering and output stages stay well inside it
  localparam int unsigned FAST_HOLD = FAST_RESP_US * CLK_KHZ / 1000 / 2;
  localparam int unsigned SLOW_HOLD = SLOW_RESP_US * CLK_KHZ / 1000 / 2;

  // Decoded input functions
  typedef struct packed {
    logic inch;
    logic second;
    logic cur_sel;
    logic fifteen;
    logic high;
    logic mid;
    logic low;
    logic panel_il;
    logic pid;
    logic vf;
  } ifs_func_s;

  // Speed command source, lowest priority first
  typedef enum logic [1:0] {SRC_ANALOG, SRC_PID, SRC_MULTI, SRC_INCH} ifs_speed_src_e;
endpackage : ifs_pkg

// ---- core/ifs_filter.sv ----
// Per-bit stability filter that passes a level after it holds for a set count
module ifs_filter #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned HOLD = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  localparam int unsigned CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD - 1);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Cycles the new level has held
      logic [CW-1:0] cnt_q;
      // Glitches shorter than HOLD never reach the drive logic
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_q <= '0;
          q[i] <= 1'b0;
        end else if (d[i] == q[i]) begin
          cnt_q <= '0;
        end else if (cnt_q == LAST) begin
          cnt_q <= '0;
          q[i] <= d[i];
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
    end
  endgenerate
endmodule // ifs_filter

// ---- dv/ifs_contacts.sv ----
// Model of the external contact bank that drives the terminal inputs
module ifs_contacts (
  input wire logic clk,
  input wire logic [6:0] want,
  input wire logic [6:0] bounce,
  output logic [6:0] term_in = 7'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts move only on a clock edge. A bounce bit flips its contact while held,
  // so a pulse shorter than the filter hold can be injected on purpose.
  always @(posedge clk) begin
    term_in <= want ^ bounce;
  end
endmodule // ifs_contacts

// ---- dv/testbench.sv ----
// Self-checking bench for the input function and shutoff block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Small filter counts keep the run short; every settle wait derives from them
  localparam int FC = 3;
  localparam int SC = 5;
  logic clk = 1'b0, rst = 1'b1, start_cmd = 1'b0, motor_running = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
  logic [6:0] want = 7'h00, bounce = 7'h00, term_in;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv;
  logic gate, coast, decel, panel, second, vf, volt, racc, rdec, rclr;
  logic [1:0] src;
  logic [3:0] step;
  int num_errors = 0, cmp_count = 0;
  int seed = 32'h456C2811;
  // Reference state of the registers as software set them
  int m_logic = 0, m_group = 0, m_mode = 0, m_ctrl = 0;
  bit m_vf = 0;
  int m_code[7] = '{60, 61, 0, 1, 2, 24, 62};
  // First map puts the panel interlock on a terminal, second map the run enable
  int maps[2][7] = '{'{3, 3, 4, 18, 5, 12, 9999}, '{0, 1, 2, 8, 5, 14, 10}};
  int lgs[3] = '{0, 2, 4};
  // Clock of 100 ns period
  always #50 clk = ~clk;
  ifs_contacts contacts (.clk(clk), .want(want), .bounce(bounce), .term_in(term_in));
  ifs_input_shutoff #(.FAST_CNT(FC), .SLOW_CNT(SC)) dut (.clk(clk), .rst(rst), .term_in(term_in),
    .start_cmd(start_cmd), .motor_running(motor_running), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .gate_enable(gate), .coast_stop(coast),
    .decel_stop(decel), .panel_op_allowed(panel), .second_set_active(second), .vf_control_active(vf),
    .voltage_input_enable(volt), .speed_source(src), .speed_step(step), .remote_accel(racc),
    .remote_decel(rdec), .remote_clear(rclr));
  // One comparison, counted, with a report on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register write; the reference copy mirrors which writes are refused
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    if (a == ifs_pkg::ADDR_LOGIC && m_group == 0 && (d == 0 || d == 2 || d == 4)) m_logic = d;
    if (a == ifs_pkg::ADDR_GROUP) m_group = d[7:0];
    if (a == ifs_pkg::ADDR_MODE) m_mode = d[3:0];
    if (a == ifs_pkg::ADDR_CTRL) m_ctrl = d[1:0];
    if (a >= ifs_pkg::ADDR_TERM0 && a < ifs_pkg::ADDR_CTRL) m_code[(a - ifs_pkg::ADDR_TERM0) / 4] = d[13:0];
  endtask
  // Register read; data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Level of a function: any terminal carrying its code and closed
  function automatic bit fn(int code);
    for (int i = 0; i < 7; i++) if (m_code[i] == code && want[i]) return 1'b1;
    return 1'b0;
  endfunction
  function automatic bit asg(int code);
    for (int i = 0; i < 7; i++) if (m_code[i] == code) return 1'b1;
    return 1'b0;
  endfunction
  // Shutoff request from terminal and communication sources per logic setting
  function automatic bit shut();
    bit t = fn(24);
    bit c = m_ctrl[0];
    if (m_logic == 0) return t | c;
    if (m_logic == 2) return !(t && c);
    return !(t && !c);
  endfunction
  // Wait a fixed number of cycles, then step past the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Compare every output level with the reference model
  task automatic check_all();
    bit al, rm, multi;
    logic [15:0] e;
    logic [31:0] s;
    al = !shut() && (asg(10) ? fn(10) : 1'b1);
    rm = m_ctrl[1];
    multi = !rm && (fn(0) | fn(1) | fn(2) | fn(8));
    if (!motor_running) m_vf = fn(18);
    e[15] = al & start_cmd;
    e[14] = !al;
    e[13] = al & !start_cmd & motor_running;
    e[12] = (m_mode != 7) ? 1'b1 : (asg(12) ? fn(12) : !shut());
    e[11] = fn(3) | fn(18);
    e[10] = m_vf;
    e[9] = !fn(4);
    e[8:7] = fn(5) ? 2'h3 : multi ? 2'h2 : fn(14) ? 2'h1 : 2'h0;
    e[6:3] = rm ? 4'h0 : {fn(8), fn(2), fn(1), fn(0)};
    e[2:0] = {rm & fn(2), rm & fn(1), rm & fn(0)};
    chk({16'h0, gate, coast, decel, panel, second, vf, volt, src, step, racc, rdec, rclr}, {16'h0, e});
    // Status word: run permission, gate, filtered run enable, shutoff and slow functions
    rd(ifs_pkg::ADDR_STATUS, s);
    chk(s, {12'h0, al, al & start_cmd, fn(10), shut(), 6'h0, fn(5), fn(3), fn(4), fn(8), fn(2), fn(1), fn(0),
            fn(12), fn(14), fn(18)});
  endtask
  // Counts line, verdict and end of run
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected five hundred or so cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values, default shutoff placement and an unmapped read
    rd(ifs_pkg::ADDR_LOGIC, rdv); chk(rdv, 32'h0);
    rd(8'h20, rdv); chk(rdv, 32'h18);
    rd(8'h24, rdv); chk(rdv, 32'h3E);
    rd(8'hF0, rdv); chk(rdv, 32'h0);
    settle(SC + 3); check_all();
    $display("Test reset done");
    // Logic setting locked while the group selection is nonzero
    wr(ifs_pkg::ADDR_GROUP, 32'h1); wr(ifs_pkg::ADDR_LOGIC, 32'h2);
    rd(ifs_pkg::ADDR_LOGIC, rdv); chk(rdv, m_logic);
    wr(ifs_pkg::ADDR_GROUP, 32'h0); wr(ifs_pkg::ADDR_LOGIC, 32'h3);
    rd(ifs_pkg::ADDR_LOGIC, rdv); chk(rdv, m_logic);
    $display("Test write lock done");
    // Full shutoff table in mode 7 with start applied, waited only the fast bound
    wr(ifs_pkg::ADDR_MODE, 32'h7);
    start_cmd <= 1'b1;
    foreach (lgs[k]) begin
      wr(ifs_pkg::ADDR_LOGIC, lgs[k]);
      for (int t = 0; t < 2; t++) for (int c = 0; c < 2; c++) begin
        @(posedge clk);
        want[5] <= t[0];
        wr(ifs_pkg::ADDR_CTRL, c);
        settle(FC + 2); check_all();
      end
    end
    $display("Test shutoff table done");
    // Start removed while running decelerates; shutoff coasts
    wr(ifs_pkg::ADDR_LOGIC, 32'h0); wr(ifs_pkg::ADDR_CTRL, 32'h0);
    want <= 7'h00; start_cmd <= 1'b0; motor_running <= 1'b1;
    settle(FC + 3); check_all();
    @(posedge clk);
    want[5] <= 1'b1;
    settle(FC + 3); check_all();
    // A bounce shorter than the filter hold is dropped
    @(posedge clk);
    want[5] <= 1'b0; start_cmd <= 1'b1;
    settle(FC + 3);
    @(posedge clk);
    bounce[5] <= 1'b1;
    @(posedge clk);
    bounce[5] <= 1'b0;
    settle(FC + 3); check_all();
    $display("Test stop modes done");
    // Random contacts over two function maps, local and remote speed modes
    foreach (maps[m]) begin
      for (int i = 0; i < 7; i++) wr(ifs_pkg::ADDR_TERM0 + 8'(4 * i), maps[m][i]);
      for (int r = 0; r < 2; r++) begin
        wr(ifs_pkg::ADDR_CTRL, r << 1);
        repeat (6) begin
          // Contacts add one edge before the terminal sample, hence one cycle beyond the filter path
          @(posedge clk);
          want <= 7'($random(seed));
          motor_running <= 1'($random(seed));
          settle(SC + 3); check_all();
        end
      end
    end
    $display("Test function maps done");
    print_verdict();
  end
endmodule // testbench
